// [logic/drive_defs.svh]
`ifndef DRIVE_DEFS_SVH
`define DRIVE_DEFS_SVH

// startup configuration byte selectors on the parameter write port
`define SEL_ADDR_LOW        2'h0
`define SEL_BAUD_LOW        2'h1
`define SEL_ADDR_HIGH       2'h2
`define SEL_BAUD_HIGH       2'h3

// reset values of the four startup bytes
`define ADDR_LOW_RESET      8'h3f
`define BAUD_LOW_RESET      8'h84
`define ADDR_HIGH_RESET     8'ha0
`define BAUD_HIGH_RESET     8'h50

// fixed key patterns
`define ADDR_KEY_VALUE      4'ha
`define BAUD_KEY_VALUE      4'h5

// stop method select codes
`define STOP_DECEL          16'h270f
`define STOP_RUNDIR         16'h22b8
`define STOP_COAST_MAX      16'h0064
`define STOP_DIR_MIN        16'h03e8
`define STOP_DIR_MAX        16'h044c

// assembly identifiers
`define IN_ASM_ID_0         8'h46
`define IN_ASM_ID_1         8'h47
`define IN_ASM_ID_6         8'hb0
`define IN_ASM_ID_8         8'h96
`define OUT_ASM_ID_0        8'h14
`define OUT_ASM_ID_1        8'h15
`define OUT_ASM_ID_6        8'h7e
`define OUT_ASM_ID_8        8'h64

// timing
`define CLK_FREQ_HZ         200000000
`define GF_CHECK_TIME_MS    20
`define GF_CHECK_CYCLES     (`CLK_FREQ_HZ / 1000 * `GF_CHECK_TIME_MS)
`define CYCLES_PER_SECOND   `CLK_FREQ_HZ

// alarm code shown while the ground fault alarm stands (arbitrary value)
`define GF_ALARM_CODE       8'h40

`endif

// [logic/drive_pkg.sv]
package drive_pkg;

  typedef struct packed {
    logic [3:0] addr_key;
    logic [1:0] watchdog_timeout_action;
    logic [1:0] network_fault_action;
    logic [1:0] spare;
    logic [5:0] node_address;
  } addr_cfg_t;

  typedef struct packed {
    logic [3:0] baud_key;
    logic       spare_hi;
    logic [3:0] input_assembly;
    logic       spare_lo;
    logic [3:0] output_assembly;
    logic [1:0] baud_rate;
  } baud_cfg_t;

  typedef struct packed {
    logic [5:0] node_address;
    logic [1:0] baud_rate;
    logic [7:0] consumed_asm_id;
    logic [7:0] produced_asm_id;
  } net_active_t;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_GF_CHECK = 3'b001,
    ST_RUN      = 3'b010,
    ST_DECEL    = 3'b011,
    ST_HOLD     = 3'b100,
    ST_FAULT    = 3'b101
  } drive_state_t;

endpackage

// [logic/drive_start_stop_netcfg.sv]
// Behaviour
// R1: ground fault check select 0 skips start check, 1 checks at every start; the code skips the check for a start during decel or hold.
// R2: with check enabled, output enable waits about 20 ms after each start.
// R3: fault found during check raises ground fault alarm code, output off.
// R4: stop method select decides how the drive stops when start drops.
// R5: setting 9999 ramps the motor down to standstill on start removal.
// R6: setting 0 to 100 s keeps output that long, then coasts.
// R7: setting 0 shuts output off as quickly as possible.
// R8: setting 8888 makes first input run/stop and second input direction.
// R9: setting 1000 to 1100 decodes as 8888 and coasts after its delay.
// R10: running indication drops when output actually stops.
// R11: start during coasting restarts output frequency from 0 Hz.
// R12: address word is high/low address bytes: key, watchdog, fault, node.
// R13: baud word is high/low baud bytes: key, in asm, out asm, rate.
// R14: watchdog action 0 timeout, 1 auto delete, 2 auto reset, default 0.
// R15: network fault action 0 fault and stop, 1 ignore, default 0.
// R16: input assembly code 0,1,6,8 gives 70,71,176,150; default 1.
// R17: output assembly code 0,1,6,8 gives 20,21,126,100; default 1.
// R18: baud code 0,1,2 is 125, 250, 500 kbps; default 0.
// R19: node address 0 to 63, default 63.
// R20: key fields accept only 1010 address key and 0101 baud key.
// R21: reconnect after disconnection restores watchdog action to 0.
// R22: master normally sets configuration fields over the network link.
// R23: node, baud and assembly apply at network startup only.
// R24: ground fault check runs only right after a start command.
`timescale 1ns/1ps
`include "drive_defs.svh"

module drive_start_stop_netcfg #(
  parameter int unsigned GF_CHECK_CYC = `GF_CHECK_CYCLES,
  parameter int unsigned SEC_CYC      = `CYCLES_PER_SECOND
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // run command inputs
  input  wire logic                  forward_run_input,
  input  wire logic                  reverse_run_input,
  // settings
  input  wire logic                  ground_fault_check_select,
  input  wire logic [15:0]           stop_method_select,
  // power stage feedback
  input  wire logic                  ground_fault_sense,
  input  wire logic                  motor_standstill,
  input  wire logic                  alarm_reset,
  // startup configuration byte write port
  input  wire logic                  cfg_wr_en,
  input  wire logic [1:0]            cfg_wr_sel,
  input  wire logic [7:0]            cfg_wr_data,
  // network link state
  input  wire logic                  net_connected,
  input  wire logic                  net_startup,
  // drive outputs
  output logic                       output_enable,
  output logic                       reverse_dir,
  output logic                       decel_request,
  output logic                       running,
  output logic                       freq_from_zero,
  output logic                       ground_fault_alarm,
  output logic [7:0]                 ground_fault_alarm_code,
  // configuration readback
  output drive_pkg::addr_cfg_t       addr_cfg_word,
  output drive_pkg::baud_cfg_t       baud_cfg_word,
  output drive_pkg::net_active_t     net_active
);

  drive_pkg::drive_state_t state_reg;
  drive_pkg::drive_state_t state_next;

  logic [7:0]  addr_low_reg;
  logic [7:0]  addr_high_reg;
  logic [7:0]  baud_low_reg;
  logic [7:0]  baud_high_reg;

  logic [31:0] cyc_reg;
  logic [31:0] cyc_next;
  logic [6:0]  sec_reg;
  logic [6:0]  sec_next;

  logic        dir_reg;
  logic        dir_next;
  logic        alarm_reg;
  logic        alarm_next;
  logic        coast_reg;
  logic        coast_next;
  logic        zero_reg;
  logic        zero_next;

  logic        net_lost_reg;
  logic        net_prev_reg;
  drive_pkg::net_active_t active_reg;

  // stop method decode
  wire        mode_decel  = (stop_method_select == `STOP_DECEL);                // R5
  wire        mode_coast  = (stop_method_select <= `STOP_COAST_MAX);            // R6
  wire        mode_dirdly = (stop_method_select >= `STOP_DIR_MIN) &&
                            (stop_method_select <= `STOP_DIR_MAX);
  wire        mode_rundir = (stop_method_select == `STOP_RUNDIR) || mode_dirdly; // R8 R9
  wire [15:0] dly_full    = mode_dirdly ? (stop_method_select - `STOP_DIR_MIN)
                                        : stop_method_select;
  wire [6:0]  delay_sec   = dly_full[6:0];
  wire        delay_zero  = (delay_sec == 7'h00);                               // R7
  // a zero delay in either timed range means no hold at all
  wire        hold_entry  = (mode_coast || mode_dirdly) && !delay_zero;         // R6 R9

  // command decode
  wire start_std  = forward_run_input ^ reverse_run_input;
  wire dir_std    = reverse_run_input & ~forward_run_input;
  wire start_cmd  = mode_rundir ? forward_run_input : start_std;                // R8
  wire dir_cmd    = mode_rundir ? reverse_run_input : dir_std;                  // R8

  // state decode
  wire in_idle     = (state_reg == drive_pkg::ST_IDLE);
  wire in_run      = (state_reg == drive_pkg::ST_RUN);
  wire in_decel    = (state_reg == drive_pkg::ST_DECEL);
  wire in_hold     = (state_reg == drive_pkg::ST_HOLD);

  // timers
  wire cyc_gf_done = (cyc_reg >= GF_CHECK_CYC - 1);
  wire cyc_sec     = (cyc_reg >= SEC_CYC - 1);
  // the hold ends on the tick that brings the count to the setting, so the output
  // stands exactly the set number of seconds after start drops
  wire [6:0] sec_after_tick = sec_reg + 7'h01;
  wire hold_done   = cyc_sec && (sec_after_tick >= delay_sec);                  // R6 R9
  // the start event is only taken from idle, so the fault check never runs mid-operation
  wire start_evt   = start_cmd && in_idle;                                      // R24

  // network reconnection
  wire net_rise    = net_connected && !net_prev_reg;

  // sequencer; every stop path ends in idle, though a start during decel or hold goes straight back to run
  always_comb begin
    state_next = state_reg;
    cyc_next   = 32'h0000_0000;
    sec_next   = 7'h00;
    dir_next   = dir_reg;
    alarm_next = alarm_reg;
    coast_next = coast_reg && !motor_standstill;
    zero_next  = zero_reg;

    unique case (state_reg)
      drive_pkg::ST_IDLE: begin
        if (start_evt) begin
          dir_next  = dir_cmd;
          zero_next = coast_reg;                                                // R11
          if (ground_fault_check_select) begin                                  // R1
            state_next = drive_pkg::ST_GF_CHECK;
          end else begin
            state_next = drive_pkg::ST_RUN;
          end
        end
      end

      drive_pkg::ST_GF_CHECK: begin
        // sense is honoured only inside this window; faults while running go unseen
        cyc_next = cyc_reg + 32'h0000_0001;                                     // R2
        if (ground_fault_sense) begin
          alarm_next = 1'b1;                                                    // R3
          state_next = drive_pkg::ST_FAULT;
        end else if (!start_cmd) begin
          state_next = drive_pkg::ST_IDLE;
        end else if (cyc_gf_done) begin
          state_next = drive_pkg::ST_RUN;                                       // R2
        end
      end

      drive_pkg::ST_RUN: begin
        // the stop method is fixed on the edge at which start is seen low
        zero_next = 1'b0;
        if (start_cmd) begin
          dir_next = dir_cmd;
        end else if (mode_decel) begin                                          // R4 R5
          state_next = drive_pkg::ST_DECEL;
        end else if (hold_entry) begin                                          // R6 R9
          state_next = drive_pkg::ST_HOLD;
        end else begin
          state_next = drive_pkg::ST_IDLE;                                      // R7
          coast_next = 1'b1;
        end
      end

      drive_pkg::ST_DECEL: begin
        // a new start during the ramp resumes without another fault check
        if (start_cmd) begin
          state_next = drive_pkg::ST_RUN;
          dir_next   = dir_cmd;
        end else if (motor_standstill) begin
          state_next = drive_pkg::ST_IDLE;                                      // R10
        end
      end

      drive_pkg::ST_HOLD: begin
        // output is still on here, so a new start needs no restart from 0 Hz
        cyc_next = cyc_sec ? 32'h0000_0000 : cyc_reg + 32'h0000_0001;
        sec_next = cyc_sec ? sec_reg + 7'h01 : sec_reg;
        if (start_cmd) begin
          state_next = drive_pkg::ST_RUN;
          dir_next   = dir_cmd;
        end else if (hold_done) begin
          state_next = drive_pkg::ST_IDLE;                                      // R6 R9
          coast_next = 1'b1;
        end
      end

      drive_pkg::ST_FAULT: begin
        // output stays off until the alarm is cleared; the motor is left coasting
        if (alarm_reset) begin
          alarm_next = 1'b0;
          state_next = drive_pkg::ST_IDLE;
          coast_next = 1'b1;
        end
      end

      default: begin
        state_next = drive_pkg::ST_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= drive_pkg::ST_IDLE;
      cyc_reg   <= 32'h0000_0000;
      sec_reg   <= 7'h00;
      dir_reg   <= 1'b0;
      alarm_reg <= 1'b0;
      coast_reg <= 1'b0;
      zero_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cyc_reg   <= cyc_next;
      sec_reg   <= sec_next;
      dir_reg   <= dir_next;
      alarm_reg <= alarm_next;
      coast_reg <= coast_next;
      zero_reg  <= zero_next;
    end
  end

  // drive outputs; output stays off through the whole check window
  wire out_on = in_run || in_decel || in_hold;                                  // R2 R3

  assign output_enable           = out_on;
  assign running                 = out_on;                                      // R10
  assign decel_request           = in_decel;                                    // R5
  assign reverse_dir             = dir_reg;
  assign freq_from_zero          = zero_reg;                                    // R11
  assign ground_fault_alarm      = alarm_reg;                                   // R3
  assign ground_fault_alarm_code = alarm_reg ? `GF_ALARM_CODE : 8'h00;          // R3

  // configuration bytes; key nibbles are forced so only the fixed pattern is held
  wire wr_addr_low  = cfg_wr_en && (cfg_wr_sel == `SEL_ADDR_LOW);
  wire wr_addr_high = cfg_wr_en && (cfg_wr_sel == `SEL_ADDR_HIGH);
  wire wr_baud_low  = cfg_wr_en && (cfg_wr_sel == `SEL_BAUD_LOW);
  wire wr_baud_high = cfg_wr_en && (cfg_wr_sel == `SEL_BAUD_HIGH);
  wire [7:0] addr_high_wr = {`ADDR_KEY_VALUE, cfg_wr_data[3:0]};                // R20
  wire [7:0] baud_high_wr = {`BAUD_KEY_VALUE, cfg_wr_data[3:0]};                // R20
  // node address above 63 cannot be stored: upper two bits of the low byte are spare
  wire [7:0] addr_low_wr  = {2'h0, cfg_wr_data[5:0]};                           // R19
  // baud rate code 3 is undefined and is refused, other fields still written
  wire [1:0] baud_wr      = (cfg_wr_data[1:0] == 2'h3) ? baud_low_reg[1:0]
                                                       : cfg_wr_data[1:0];      // R18

  // link state history: a rise only counts as a reconnection after a seen loss
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      net_lost_reg <= 1'b0;
      net_prev_reg <= 1'b0;
    end else begin
      net_prev_reg <= net_connected;
      if (net_prev_reg && !net_connected) begin
        net_lost_reg <= 1'b1;
      end else if (net_rise) begin
        net_lost_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_low_reg  <= `ADDR_LOW_RESET;
      addr_high_reg <= `ADDR_HIGH_RESET;
      baud_low_reg  <= `BAUD_LOW_RESET;
      baud_high_reg <= `BAUD_HIGH_RESET;
    end else begin
      if (wr_addr_low) begin
        addr_low_reg <= addr_low_wr;
      end

      // reconnection wins over a write to the same byte in that cycle
      if (net_rise && net_lost_reg) begin
        addr_high_reg <= {addr_high_reg[7:4], 2'h0, addr_high_reg[1:0]};        // R21
      end else if (wr_addr_high) begin
        addr_high_reg <= addr_high_wr;                                          // R14 R15
      end

      if (wr_baud_low) begin
        baud_low_reg <= {cfg_wr_data[7:2], baud_wr};
      end

      if (wr_baud_high) begin
        baud_high_reg <= baud_high_wr;
      end
    end
  end

  assign addr_cfg_word = {addr_high_reg, addr_low_reg};                         // R12
  assign baud_cfg_word = {baud_high_reg, baud_low_reg};                         // R13

  // assembly code lookup; unlisted codes fall back to the default code 1
  function automatic logic [7:0] in_asm_id(input logic [3:0] code);
    unique case (code)
      4'h0:    in_asm_id = `IN_ASM_ID_0;
      4'h6:    in_asm_id = `IN_ASM_ID_6;
      4'h8:    in_asm_id = `IN_ASM_ID_8;
      default: in_asm_id = `IN_ASM_ID_1;
    endcase
  endfunction

  function automatic logic [7:0] out_asm_id(input logic [3:0] code);
    unique case (code)
      4'h0:    out_asm_id = `OUT_ASM_ID_0;
      4'h6:    out_asm_id = `OUT_ASM_ID_6;
      4'h8:    out_asm_id = `OUT_ASM_ID_8;
      default: out_asm_id = `OUT_ASM_ID_1;
    endcase
  endfunction

  wire [7:0] consumed_id = in_asm_id(baud_cfg_word.input_assembly);             // R16
  wire [7:0] produced_id = out_asm_id(baud_cfg_word.output_assembly);           // R17

  // link settings are sampled only at startup so a live write cannot move the node
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      active_reg <= {6'h3f, 2'h0, `IN_ASM_ID_1, `OUT_ASM_ID_1};
    end else if (net_startup) begin
      active_reg <= {addr_cfg_word.node_address, baud_cfg_word.baud_rate,
                     consumed_id, produced_id};                                 // R23
    end
  end

  assign net_active = active_reg;

endmodule // drive_start_stop_netcfg

// [tb/drive_start_stop_netcfg_properties.sv]
`timescale 1ns/1ps
module drive_start_stop_checker #(
  parameter int unsigned GF_CHECK_CYC = 4,
  parameter int unsigned SEC_CYC      = 10
) (
  // clock and reset
  input wire logic                   ref_clk,
  input wire logic                   rst,
  // inputs
  input wire logic                   forward_run_input,
  input wire logic                   reverse_run_input,
  input wire logic                   ground_fault_check_select,
  input wire logic [15:0]            stop_method_select,
  input wire logic                   ground_fault_sense,
  input wire logic                   motor_standstill,
  input wire logic                   net_connected,
  input wire logic                   net_startup,
  // outputs
  input wire logic                   output_enable,
  input wire logic                   decel_request,
  input wire logic                   running,
  input wire logic                   ground_fault_alarm,
  input wire logic [7:0]             ground_fault_alarm_code,
  input wire drive_pkg::addr_cfg_t   addr_cfg_word,
  input wire drive_pkg::baud_cfg_t   baud_cfg_word,
  input wire drive_pkg::net_active_t net_active
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire dir_mode  = stop_method_select == 16'h22b8 ||
                   (stop_method_select >= 16'h03e8 && stop_method_select <= 16'h044c);
  wire start_cmd = dir_mode ? forward_run_input : forward_run_input ^ reverse_run_input;
  wire idle_ok   = !output_enable && !ground_fault_alarm && start_cmd;
  // repetition count follows the bench value of GF_CHECK_CYC
  sequence s_take; idle_ok && ground_fault_check_select && !$past(start_cmd); endsequence
  sequence s_clean; (start_cmd && !ground_fault_sense)[*4]; endsequence
  property p_skip; idle_ok && !ground_fault_check_select |=> output_enable; endproperty
  property p_chk_hold; s_take |=> !output_enable[*4]; endproperty
  property p_chk_done; s_take ##1 s_clean |=> output_enable; endproperty
  property p_gf_alarm; s_take ##1 ground_fault_sense |-> ##[1:2] ground_fault_alarm; endproperty
  property p_gf_off;
    ground_fault_alarm |-> !output_enable && ground_fault_alarm_code == 8'h40;
  endproperty
  property p_decel;
    output_enable && !start_cmd && stop_method_select == 16'h270f && !motor_standstill
      |=> output_enable && decel_request;
  endproperty
  property p_immediate;
    output_enable && !start_cmd && stop_method_select == 16'h0000 |=> !output_enable;
  endproperty
  property p_run_ind; running == output_enable; endproperty
  property p_keys; addr_cfg_word.addr_key == 4'ha && baud_cfg_word.baud_key == 4'h5; endproperty
  property p_reconnect;
    $rose(net_connected) |=> addr_cfg_word.watchdog_timeout_action == 2'h0;
  endproperty
  property p_apply;
    net_startup |=> net_active.node_address == $past(addr_cfg_word.node_address);
  endproperty
  property p_hold_active; !net_startup |=> $stable(net_active); endproperty
  a_skip: assert property (p_skip) else $error("output not enabled after unchecked start");
  a_chk_hold: assert property (p_chk_hold) else $error("output enabled during check");
  a_chk_done: assert property (p_chk_done) else $error("output late after check");
  a_gf_alarm: assert property (p_gf_alarm) else $error("ground fault not raised");
  a_gf_off: assert property (p_gf_off) else $error("alarm without shutoff or code");
  a_decel: assert property (p_decel) else $error("no decel on stop");
  a_immediate: assert property (p_immediate) else $error("slow immediate stop");
  a_run_ind: assert property (p_run_ind) else $error("running differs from output");
  a_keys: assert property (p_keys) else $error("key field wrong");
  a_reconnect: assert property (p_reconnect) else $error("watchdog action kept");
  a_apply: assert property (p_apply) else $error("node not applied");
  a_hold_active: assert property (p_hold_active) else $error("link settings moved");
endmodule // drive_start_stop_checker

bind drive_start_stop_netcfg drive_start_stop_checker #(
  .GF_CHECK_CYC(GF_CHECK_CYC),
  .SEC_CYC     (SEC_CYC)
) u_chk (.*);

// [tb/net_master_model.sv]
`timescale 1ns/1ps
module net_master_model (
  // clock
  input  wire logic  ref_clk,
  // command and configuration lines
  output logic       forward_run_input,
  output logic       reverse_run_input,
  output logic       cfg_wr_en,
  output logic [1:0] cfg_wr_sel,
  output logic [7:0] cfg_wr_data,
  output logic       net_connected,
  output logic       net_startup
);
  initial begin
    {forward_run_input, reverse_run_input, cfg_wr_en, net_startup} = 4'h0;
    {cfg_wr_sel, cfg_wr_data} = 10'h000;
    net_connected = 1'b1;
  end
  task automatic run(input logic f, input logic r);
    @(negedge ref_clk);
    forward_run_input = f;
    reverse_run_input = r;
  endtask
  // fields go over the link, one byte per strobe
  task automatic write(input logic [1:0] s, input logic [7:0] d);
    @(negedge ref_clk);
    {cfg_wr_en, cfg_wr_sel, cfg_wr_data} = {1'b1, s, d};
    @(negedge ref_clk);
    cfg_wr_en = 1'b0;
    cfg_wr_data = ~d;
  endtask
  task automatic reconnect();
    @(negedge ref_clk);
    net_connected = 1'b0;
    repeat (3) @(negedge ref_clk);
    net_connected = 1'b1;
    @(negedge ref_clk);
  endtask
  task automatic startup();
    @(negedge ref_clk);
    net_startup = 1'b1;
    @(negedge ref_clk);
    net_startup = 1'b0;
  endtask
endmodule // net_master_model

// [tb/drive_start_stop_netcfg_tb.sv]
`timescale 1ns/1ps
module drive_start_stop_netcfg_tb;
  logic                   ref_clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   gf_sel = 1'b0;
  logic [15:0]            sms = 16'h270f;
  logic                   gf_sense = 1'b0;
  logic                   standstill = 1'b1;
  logic                   alarm_rst = 1'b0;
  logic                   fwd, rev, wr_en, conn, startup;
  logic [1:0]             wr_sel;
  logic [7:0]             wr_data, gf_code;
  logic                   oe, rdir, decel, running, ffz, gf_alarm;
  drive_pkg::addr_cfg_t   aw;
  drive_pkg::baud_cfg_t   bw;
  drive_pkg::net_active_t na;
  int                     n_mismatch = 0;
  int                     checked = 0;
  int                     n;

  always #2.5 ref_clk = ~ref_clk;

  net_master_model m (.ref_clk(ref_clk), .forward_run_input(fwd), .reverse_run_input(rev),
    .cfg_wr_en(wr_en), .cfg_wr_sel(wr_sel), .cfg_wr_data(wr_data), .net_connected(conn),
    .net_startup(startup));

  drive_start_stop_netcfg #(.GF_CHECK_CYC(4), .SEC_CYC(10)) dut (.ref_clk(ref_clk), .rst(rst),
    .forward_run_input(fwd), .reverse_run_input(rev), .ground_fault_check_select(gf_sel),
    .stop_method_select(sms), .ground_fault_sense(gf_sense), .motor_standstill(standstill),
    .alarm_reset(alarm_rst), .cfg_wr_en(wr_en), .cfg_wr_sel(wr_sel), .cfg_wr_data(wr_data),
    .net_connected(conn), .net_startup(startup), .output_enable(oe), .reverse_dir(rdir),
    .decel_request(decel), .running(running), .freq_from_zero(ffz),
    .ground_fault_alarm(gf_alarm), .ground_fault_alarm_code(gf_code), .addr_cfg_word(aw),
    .baud_cfg_word(bw), .net_active(na));

  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cnt_on(output int k);
    k = 0;
    while (oe !== 1'b1 && k < 50) begin
      @(negedge ref_clk);
      k++;
    end
  endtask
  task automatic cnt_off(output int k);
    k = 0;
    @(negedge ref_clk);
    while (oe !== 1'b0 && k < 2000) begin
      k++;
      @(negedge ref_clk);
    end
  endtask

  task automatic t_cfg();
    logic [3:0] codes [4] = '{4'h0, 4'h1, 4'h6, 4'h8};
    logic [7:0] in_id [4] = '{8'h46, 8'h47, 8'hb0, 8'h96};
    logic [7:0] out_id [4] = '{8'h14, 8'h15, 8'h7e, 8'h64};
    logic [3:0] c, o;
    logic [1:0] b;
    chk(aw, 16'ha03f, "addr reset");
    chk(bw, 16'h5084, "baud reset");
    chk(na, {6'h3f, 2'h0, 8'h47, 8'h15}, "active reset");
    m.write(2'h0, 8'h2a);
    chk(aw, 16'ha02a, "node write");
    m.write(2'h2, 8'hf5);
    chk(aw, 16'ha52a, "addr high write");
    for (int i = 0; i < 4; i++) begin
      c = codes[i];
      o = codes[3-i];
      b = 2'(i % 3);
      m.write(2'h3, {5'h00, c[3:1]});
      m.write(2'h1, {c[0], 1'b0, o, b});
      chk(bw, {4'h5, 1'b0, c, 1'b0, o, b}, "baud word");
      m.startup();
      chk(na, {6'h2a, b, in_id[i], out_id[3-i]}, "active");
    end
    m.write(2'h1, 8'h03);
    chk(bw.baud_rate, 2'h0, "baud code 3 refused");
    m.write(2'h0, 8'hc1);
    chk(aw, 16'ha501, "node range");
    chk(na.node_address, 6'h2a, "node before startup");
    m.reconnect();
    chk(aw.watchdog_timeout_action, 2'h0, "watchdog after reconnect");
    $display("test cfg done");
  endtask

  task automatic t_start();
    sms = 16'h0000;
    for (int s = 0; s < 2; s++) begin
      gf_sel = s[0];
      m.run(1'b1, 1'b0);
      cnt_on(n);
      chk(n, s ? 5 : 1, "start delay");
      gf_sense = 1'b1;
      repeat (3) @(negedge ref_clk);
      chk({gf_alarm, oe}, 2'b01, "sense while running");
      gf_sense = 1'b0;
      m.run(1'b0, 1'b0);
    end
    m.run(1'b1, 1'b0);
    @(negedge ref_clk);
    gf_sense = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk({gf_alarm, oe, gf_code}, {2'b10, 8'h40}, "ground fault");
    gf_sense = 1'b0;
    m.run(1'b0, 1'b0);
    alarm_rst = 1'b1;
    @(negedge ref_clk);
    alarm_rst = 1'b0;
    @(negedge ref_clk);
    chk({gf_alarm, gf_code}, 9'h000, "alarm cleared");
    gf_sel = 1'b0;
    $display("test start done");
  endtask

  task automatic t_stop();
    logic [15:0] modes [4] = '{16'h270f, 16'h0003, 16'h0000, 16'h03ea};
    int exp_n [4] = '{0, 30, 0, 20};
    for (int i = 0; i < 4; i++) begin
      sms = modes[i];
      m.run(1'b1, 1'b0);
      cnt_on(n);
      standstill = 1'b0;
      m.run(1'b0, 1'b0);
      if (i == 0) begin
        repeat (5) @(negedge ref_clk);
        chk({oe, decel, running}, 3'b111, "decelerating");
        standstill = 1'b1;
        cnt_off(n);
      end else begin
        cnt_off(n);
        chk(n, exp_n[i], "coast delay");
        chk(running, 1'b0, "running after stop");
        m.run(1'b1, 1'b0);
        cnt_on(n);
        chk(ffz, 1'b1, "restart from zero");
        m.run(1'b0, 1'b0);
        standstill = 1'b1;
        cnt_off(n);
      end
    end
    $display("test stop done");
  endtask

  task automatic t_dir();
    logic [15:0] modes [2] = '{16'h22b8, 16'h03e8};
    for (int i = 0; i < 2; i++) begin
      sms = modes[i];
      m.run(1'b0, 1'b1);
      repeat (3) @(negedge ref_clk);
      chk(oe, 1'b0, "direction only");
      m.run(1'b1, 1'b1);
      cnt_on(n);
      chk({oe, rdir}, 2'b11, "reverse");
      m.run(1'b0, 1'b0);
      m.run(1'b1, 1'b0);
      cnt_on(n);
      chk({oe, rdir}, 2'b10, "forward");
      m.run(1'b0, 1'b0);
      cnt_off(n);
    end
    $display("test dir done");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    t_cfg();
    t_start();
    t_stop();
    t_dir();
    close_out();
  end

  // the whole run needs a few hundred cycles
  initial begin
    #200000;
    n_mismatch++;
    $display("ERROR %0t watchdog expired", $time);
    close_out();
  end
endmodule // drive_start_stop_netcfg_tb
